// [bench/encoder_model.sv]
`timescale 1ns/10ps
module encoder_model
  import enc_pkg::*;
(
  // clock
  input  wire logic mclk,
  // encoder outputs
  output phase_s    phaseOut,
  output abs_s      absOut
);
  logic [1:0] idx = 2'h0;

  // gray order, a leads b when turning forward
  assign phaseOut = '{a: idx[1] ^ idx[0], b: idx[1]};

  initial absOut = '0;

  task automatic move(input int n, input bit up, input int gap);
    repeat (n) begin
      repeat (gap) @(posedge mclk);
      idx <= up ? idx + 2'h1 : idx - 2'h1;
    end
  endtask

  // both phases at once, an illegal step
  task automatic jump();
    @(posedge mclk);
    idx <= idx + 2'h2;
  endtask

  task automatic sample(input logic [19:0] ang, input logic [11:0] rev);
    @(posedge mclk);
    absOut <= '{valid: 1'b1, fault: absOut.fault, angle: ang, revs: rev};
    @(posedge mclk);
    absOut.valid <= 1'b0;
    // stale word must not look like a fresh one
    absOut.angle <= ~ang;
    absOut.revs  <= ~rev;
  endtask

  task automatic fault(input logic f);
    @(posedge mclk);
    absOut.fault <= f;
  endtask
endmodule // encoder_model

// [bench/testbench.sv]
`timescale 1ns/10ps
module testbench
  import enc_pkg::*;
;
  localparam int unsigned GATE = 200;
  logic        mclk;
  logic        nrst;
  bus_s        busIn;
  logic [31:0] rdata;
  phase_s      phaseIn;
  abs_s        absIn;
  logic        driveStopped;
  logic        motorStopped;
  logic [3:0]  calState;
  logic [31:0] expQ[$];
  logic        rdQ;
  int          error_cnt;
  int          checks;
  int          n;

  encoder_position_tracker #(.GATE_CYCLES(GATE)) encoder_position_tracker_i (
    .mclk(mclk), .nrst(nrst), .busIn(busIn), .rdata(rdata),
    .phaseIn(phaseIn), .absIn(absIn), .driveStopped(driveStopped),
    .motorStopped(motorStopped), .calState(calState));

  encoder_model encoder_model_i (
    .mclk(mclk), .phaseOut(phaseIn), .absOut(absIn));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    busIn <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    busIn.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge mclk);
    busIn <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge mclk);
    busIn.rd <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // read data stand from the cycle after the strobe until the next read
  always @(posedge mclk) begin
    rdQ <= busIn.rd;
  end

  always @(negedge mclk) begin
    if (rdQ === 1'b1) begin
      cmp(rdata, expQ.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    busIn = '0;
    driveStopped = 1'b1;
    motorStopped = 1'b1;
    error_cnt = 0;
    checks = 0;
    rdQ = 1'b0;
    void'($urandom(13));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_EDGES, 32'h0);
    rd(ADDR_LINES, 32'h00000800);
    rd(ADDR_GMOT, 32'h1);
    rd(ADDR_REVS, 32'h0);
    rd(ADDR_LOAD, 32'h0);
    rd(ADDR_CAL, 32'h0);
    rd(8'h40, 32'h0);
    $display("test reset done");
    n = $urandom_range(20, 1);
    encoder_model_i.move(n, 1'b1, 3);
    repeat (6) @(posedge mclk);
    rd(ADDR_EDGES, 32'(n));
    encoder_model_i.jump();
    repeat (6) @(posedge mclk);
    rd(ADDR_EDGES, 32'(n));
    encoder_model_i.move(2, 1'b0, 3);
    repeat (6) @(posedge mclk);
    rd(ADDR_EDGES, 32'(n - 2));
    wr(ADDR_CTRL, 32'h1);
    encoder_model_i.move(4, 1'b1, 3);
    repeat (6) @(posedge mclk);
    rd(ADDR_EDGES, 32'(n - 6));
    wr(ADDR_CTRL, 32'h2);
    encoder_model_i.move(3, 1'b1, 3);
    repeat (6) @(posedge mclk);
    rd(ADDR_EDGES, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    $display("test edges done");
    wr(ADDR_LINES, 32'd249);
    rd(ADDR_LINES, 32'h00000800);
    wr(ADDR_LINES, 32'd250);
    rd(ADDR_LINES, 32'd250);
    wr(ADDR_GMOT, 32'h0);
    rd(ADDR_GMOT, 32'h1);
    wr(ADDR_GLOAD, 32'h88CA6BFF);
    rd(ADDR_GLOAD, 32'h1);
    wr(ADDR_GLOAD, GLOAD_MIN);
    rd(ADDR_GLOAD, GLOAD_MIN);
    $display("test settings done");
    // one edge per 10 cycles gives 20 edges in every gate
    fork
      encoder_model_i.move(80, 1'b1, 10);
      begin
        repeat (700) @(posedge mclk);
        rd(ADDR_RPS, 32'(20 * 1000 * (CLK_HZ / GATE) / 1000));
        rd(ADDR_RPM, 32'(20 * 1000 * (CLK_HZ / GATE) / 1000 * 60));
      end
    join
    wr(ADDR_CTRL, 32'h1);
    fork
      encoder_model_i.move(80, 1'b1, 10);
      begin
        repeat (700) @(posedge mclk);
        rd(ADDR_RPS, 32'(0 - 20 * 1000 * (CLK_HZ / GATE) / 1000));
      end
    join
    $display("test speed done");
    driveStopped <= 1'b0;
    motorStopped <= 1'b0;
    wr(ADDR_CTRL, 32'h1C);
    repeat (8) @(posedge mclk);
    rd(ADDR_CAL, 32'h1);
    driveStopped <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(ADDR_CAL, 32'h2);
    motorStopped <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(ADDR_CAL, 32'h4);
    encoder_model_i.sample(20'd100, 12'hABC);
    rd(ADDR_CAL, 32'h5);
    encoder_model_i.sample(20'd100, 12'hABC);
    rd(ADDR_CAL, 32'h6);
    rd(ADDR_REVS, 32'h00000ABC);
    rd(ADDR_CTRL, 32'h18);
    rd(ADDR_ANGLE, 32'd100);
    wr(ADDR_ZOFF, 32'd40);
    rd(ADDR_ANGLE, 32'd60);
    encoder_model_i.fault(1'b1);
    repeat (8) @(posedge mclk);
    rd(ADDR_CAL, 32'h7);
    wr(ADDR_CTRL, 32'h1C);
    repeat (80) @(posedge mclk);
    rd(ADDR_CAL, 32'h8);
    cmp({28'h0, calState}, 32'h8);
    encoder_model_i.fault(1'b0);
    wr(ADDR_CTRL, 32'h08);
    repeat (4) @(posedge mclk);
    encoder_model_i.sample(20'd300, 12'h001);
    encoder_model_i.sample(20'd340, 12'h002);
    rd(ADDR_CAL, 32'h9);
    rd(ADDR_LOAD, 32'd300);
    rd(ADDR_REVS, 32'h00000ABC);
    $display("test calibration done");
    repeat (4) @(posedge mclk);
    end_of_test();
  end
endmodule // testbench

// [core/enc_pkg.sv]
// How it works
// - phases A and B, quarter period apart
// - direction from joint A/B state
// - every edge of either phase counts, unless both phases change at once
// - edge counter zero after reset
// - clear control holds edge counter zero
// - rps equals edges/s over four lines
// - speed also shown in rpm
// - turn counter starts zero, counts turns
// - multi-turn encoder loads turn counter
// - turn counter runs past 4095
// - 32-bit turns, low 12 match encoder
// - gear terms range limited, load signed
// - load position starts equal to motor, except in multi-turn mode
// - motor angle and load angle reported
// - zero offset subtracted from shaft angle
// - absolute reading aligned to incremental count
// - calibration state codes 0 to 9
// - limited retries, then failed state
// - power-up, encoder type or line count change, retry restart calibration
// - retry request self-clears when finished
// - invert negates speed and count direction
// - line count accepted 250 to 262143
package enc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned GATE_MS       = 100;
  localparam int unsigned GATE_CYC      = GATE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SPEED_MILLI   = 1000;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam logic [5:0]  DIV_STEPS     = 6'h28;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_LINES = 8'h04;
  localparam logic [7:0] ADDR_GMOT  = 8'h08;
  localparam logic [7:0] ADDR_GLOAD = 8'h0C;
  localparam logic [7:0] ADDR_ZOFF  = 8'h10;
  localparam logic [7:0] ADDR_EDGES = 8'h14;
  localparam logic [7:0] ADDR_RPS   = 8'h18;
  localparam logic [7:0] ADDR_RPM   = 8'h1C;
  localparam logic [7:0] ADDR_ANGLE = 8'h20;
  localparam logic [7:0] ADDR_REVS  = 8'h24;
  localparam logic [7:0] ADDR_LOAD  = 8'h28;
  localparam logic [7:0] ADDR_CAL   = 8'h2C;

  // control fields
  localparam int CTRL_INVERT = 0;
  localparam int CTRL_CLEAR  = 1;
  localparam int CTRL_RETRY  = 2;
  localparam int CTRL_ABS    = 3;
  localparam int CTRL_MULTI  = 4;

  // settings limits and reset values
  localparam int unsigned ANGLE_W = 20;
  localparam logic [17:0] LINES_MIN = 18'h000FA;
  localparam logic [17:0] LINES_RST = 18'h00800;
  localparam logic [31:0] GMOT_MIN  = 32'h00000001;
  localparam logic [31:0] GEAR_MAX  = 32'h77359400;
  localparam logic [31:0] GLOAD_MIN = 32'h88CA6C00;
  localparam logic [31:0] GEAR_RST  = 32'h00000001;

  // calibration codes
  localparam logic [3:0] CAL_NOT_REQ   = 4'h0;
  localparam logic [3:0] CAL_DRIVE_RUN = 4'h1;
  localparam logic [3:0] CAL_MOTOR_RUN = 4'h2;
  localparam logic [3:0] CAL_ENC_FAULT = 4'h3;
  localparam logic [3:0] CAL_BUSY      = 4'h4;
  localparam logic [3:0] CAL_IDENT     = 4'h5;
  localparam logic [3:0] CAL_DONE      = 4'h6;
  localparam logic [3:0] CAL_LOST      = 4'h7;
  localparam logic [3:0] CAL_FAILED    = 4'h8;
  localparam logic [3:0] CAL_WARN      = 4'h9;
  localparam logic [2:0] CAL_TRIES     = 3'h3;
  localparam logic [19:0] MATCH_TOL    = 20'h00004;
  localparam logic [19:0] WARN_TOL     = 20'h00040;

  typedef struct packed {
    logic a;
    logic b;
  } phase_s;

  typedef struct packed {
    logic step;
    logic up;
    logic bad;
  } quad_s;

  typedef struct packed {
    logic         valid;
    logic         fault;
    logic [19:0]  angle;
    logic [11:0]  revs;
  } abs_s;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [7:0]   addr;
    logic [31:0]  wdata;
  } bus_s;

endpackage

// [core/encoder_position_tracker.sv]
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module encoder_position_tracker
  import enc_pkg::*;
#(
  parameter int unsigned GATE_CYCLES = GATE_CYC
)(
  // system
  input  wire logic   mclk,
  input  wire logic   nrst,
  // register port
  input  wire bus_s   busIn,
  output logic [31:0] rdata,
  // encoder feedback
  input  wire phase_s phaseIn,
  input  wire abs_s   absIn,
  // drive condition
  input  wire logic   driveStopped,
  input  wire logic   motorStopped,
  // calibration status
  output logic [3:0]  calState
);

  typedef enum logic [1:0] {C_CHECK, C_LOAD, C_MATCH, C_END} cal_e;

  localparam logic [39:0] SPEED_SCALE =
    40'(longint'(SPEED_MILLI) * CLK_HZ / GATE_CYCLES);

  quad_s              quad;
  logic               invert_r;
  logic               clear_r;
  logic               retry_r;
  logic               absEn_r;
  logic               multi_r;
  logic               boot_r;
  logic [17:0]        lines_r;
  logic [31:0]        gMot_r;
  logic signed [31:0] gLoad_r;
  logic [19:0]        zoff_r;
  logic signed [31:0] edgeCount_r;
  logic [19:0]        posInRev_r;
  logic [31:0]        revCount_r;
  logic [19:0]        loadAngle_r;
  logic signed [34:0] residue_r;
  cal_e               state_r;
  logic [2:0]         tries_r;
  logic [31:0]        gateCnt_r;
  logic signed [31:0] winEdges_r;
  logic               speedNeg_r;
  logic [39:0]        divNum_r;
  logic [20:0]        divRem_r;
  logic [19:0]        divDen_r;
  logic [5:0]         divCnt_r;
  logic signed [31:0] speedRps_r;
  logic signed [31:0] speedRpm_r;

  logic wrCtrl, wrLines, wrGmot, wrGload, wrZoff, setRetry;
  logic linesOk, gMotOk, gLoadOk, typeChg, calStart, calLoad;
  logic failAttempt, gateEnd, remGe;
  logic [19:0] edgesPerRev, revTop, mismatch, angleShown;
  logic [20:0] remSh, angleDiff;
  logic [31:0] winMag, quotNow;
  logic signed [31:0] stepVal;
  logic signed [34:0] gMotExt, residueNxt;

  quad_decoder u_quad (
    .mclk    (mclk),
    .nrst    (nrst),
    .phaseIn (phaseIn),
    .invert  (invert_r),
    .quadOut (quad)
  );

  // register writes
  assign wrCtrl   = busIn.wr && busIn.addr == ADDR_CTRL;
  assign wrLines  = busIn.wr && busIn.addr == ADDR_LINES;
  assign wrGmot   = busIn.wr && busIn.addr == ADDR_GMOT;
  assign wrGload  = busIn.wr && busIn.addr == ADDR_GLOAD;
  assign wrZoff   = busIn.wr && busIn.addr == ADDR_ZOFF;
  assign setRetry = wrCtrl && busIn.wdata[CTRL_RETRY];
  assign linesOk  = busIn.wdata[31:18] == '0
                    && busIn.wdata[17:0] >= LINES_MIN;
  assign gMotOk   = busIn.wdata >= GMOT_MIN && busIn.wdata <= GEAR_MAX;
  assign gLoadOk  = $signed(busIn.wdata) >= $signed(GLOAD_MIN)
                    && $signed(busIn.wdata) <= $signed(GEAR_MAX);
  assign typeChg  = wrCtrl && (busIn.wdata[CTRL_ABS] != absEn_r
                    || busIn.wdata[CTRL_MULTI] != multi_r);
  assign calStart = boot_r || typeChg || (wrLines && linesOk)
                    || setRetry;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      invert_r <= 1'b0;
      clear_r  <= 1'b0;
      absEn_r  <= 1'b0;
      multi_r  <= 1'b0;
      boot_r   <= 1'b1;
      lines_r  <= LINES_RST;
      gMot_r   <= GEAR_RST;
      gLoad_r  <= GEAR_RST;
      zoff_r   <= '0;
    end else begin
      boot_r <= 1'b0;
      if (wrCtrl) begin
        invert_r <= busIn.wdata[CTRL_INVERT];
        clear_r  <= busIn.wdata[CTRL_CLEAR];
        absEn_r  <= busIn.wdata[CTRL_ABS];
        multi_r  <= busIn.wdata[CTRL_MULTI];
      end
      if (wrLines && linesOk)
        lines_r <= busIn.wdata[17:0];
      if (wrGmot && gMotOk)
        gMot_r <= busIn.wdata;
      if (wrGload && gLoadOk)
        gLoad_r <= busIn.wdata;
      if (wrZoff && busIn.wdata[31:20] == '0
          && busIn.wdata[19:0] < edgesPerRev)
        zoff_r <= busIn.wdata[19:0];
    end
  end

  // a software set in the finishing cycle survives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      retry_r <= 1'b0;
    else if (setRetry)
      retry_r <= 1'b1;
    else if (wrCtrl || state_r == C_END)
      retry_r <= 1'b0;
  end

  // edge counter
  assign stepVal = !quad.step ? 32'sh00000000
                 : quad.up ? 32'sh00000001 : 32'shFFFFFFFF;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      edgeCount_r <= '0;
    else if (clear_r)
      edgeCount_r <= '0;
    else
      edgeCount_r <= edgeCount_r + stepVal;
  end

  // motor angle and whole turns
  assign edgesPerRev = {lines_r, 2'b00};
  assign revTop      = edgesPerRev - 20'h00001;
  assign calLoad     = state_r == C_LOAD && absIn.valid && !absIn.fault
                       && !calStart;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      posInRev_r <= '0;
      revCount_r <= '0;
    end else if (calLoad) begin
      posInRev_r <= absIn.angle;
      if (multi_r)
        revCount_r <= 32'(absIn.revs);
    end else if (quad.step) begin
      if (quad.up) begin
        if (posInRev_r >= revTop) begin
          posInRev_r <= '0;
          revCount_r <= revCount_r + 32'h00000001;
        end else begin
          posInRev_r <= posInRev_r + 20'h00001;
        end
      end else if (posInRev_r == '0) begin
        posInRev_r <= revTop;
        revCount_r <= revCount_r - 32'h00000001;
      end else begin
        posInRev_r <= posInRev_r - 20'h00001;
      end
    end
  end

  // load side by residue: one load edge drained per cycle
  assign gMotExt = 35'(gMot_r);

  always_comb begin
    residueNxt = residue_r;
    if (quad.step)
      residueNxt = quad.up ? residue_r + 35'(gLoad_r)
                           : residue_r - 35'(gLoad_r);
    if (residue_r >= gMotExt)
      residueNxt = residueNxt - gMotExt;
    else if (residue_r <= -gMotExt)
      residueNxt = residueNxt + gMotExt;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      residue_r   <= '0;
      loadAngle_r <= '0;
    end else if (calLoad && !multi_r) begin
      residue_r   <= '0;
      loadAngle_r <= absIn.angle;
    end else begin
      residue_r <= residueNxt;
      if (residue_r >= gMotExt)
        loadAngle_r <= loadAngle_r >= revTop ? '0
                       : loadAngle_r + 20'h00001;
      else if (residue_r <= -gMotExt)
        loadAngle_r <= loadAngle_r == '0 ? revTop
                       : loadAngle_r - 20'h00001;
    end
  end

  // calibration sequence
  assign angleDiff = {1'b0, absIn.angle} - {1'b0, posInRev_r};
  assign mismatch  = angleDiff[20] ? 20'(-angleDiff) : angleDiff[19:0];

  always_comb begin
    unique case (state_r)
      C_CHECK: failAttempt = absEn_r && absIn.fault;
      C_LOAD:  failAttempt = absIn.fault;
      C_MATCH: failAttempt = absIn.valid
                             && (absIn.fault || mismatch > WARN_TOL);
      C_END:   failAttempt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= C_END;
      calState <= CAL_NOT_REQ;
      tries_r  <= '0;
    end else if (calStart) begin
      state_r <= C_CHECK;
      tries_r <= '0;
    end else if (failAttempt) begin
      tries_r <= tries_r + 3'h1;
      if (tries_r + 3'h1 >= CAL_TRIES) begin
        state_r  <= C_END;
        calState <= CAL_FAILED;
      end else begin
        state_r  <= C_CHECK;
        calState <= absIn.fault ? CAL_ENC_FAULT : CAL_BUSY;
      end
    end else begin
      unique case (state_r)
        C_CHECK: begin
          if (!absEn_r) begin
            calState <= CAL_NOT_REQ;
            state_r  <= C_END;
          end else if (!driveStopped) begin
            calState <= CAL_DRIVE_RUN;
          end else if (!motorStopped) begin
            calState <= CAL_MOTOR_RUN;
          end else begin
            calState <= CAL_BUSY;
            state_r  <= C_LOAD;
          end
        end
        C_LOAD: begin
          if (absIn.valid) begin
            calState <= CAL_IDENT;
            state_r  <= C_MATCH;
          end
        end
        C_MATCH: begin
          if (absIn.valid) begin
            calState <= mismatch <= MATCH_TOL ? CAL_DONE : CAL_WARN;
            state_r  <= C_END;
          end
        end
        C_END: begin
          if (calState == CAL_DONE && absIn.fault)
            calState <= CAL_LOST;
        end
      endcase
    end
  end

  // speed over a fixed gate window, then a serial divide
  assign gateEnd = gateCnt_r == 32'(GATE_CYCLES - 1);
  assign winMag  = winEdges_r[31] ? 32'(-winEdges_r) : winEdges_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gateCnt_r  <= '0;
      winEdges_r <= '0;
      speedNeg_r <= 1'b0;
    end else if (gateEnd) begin
      gateCnt_r  <= '0;
      winEdges_r <= stepVal;
      speedNeg_r <= winEdges_r[31];
    end else begin
      gateCnt_r  <= gateCnt_r + 32'h00000001;
      winEdges_r <= winEdges_r + stepVal;
    end
  end

  assign remSh   = {divRem_r[19:0], divNum_r[39]};
  assign remGe   = remSh >= {1'b0, divDen_r};
  assign quotNow = {divNum_r[30:0], remGe};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      divNum_r <= '0;
      divRem_r <= '0;
      divDen_r <= '0;
      divCnt_r <= '0;
    end else if (gateEnd) begin
      divNum_r <= 40'(winMag * SPEED_SCALE);
      divRem_r <= '0;
      divDen_r <= edgesPerRev;
      divCnt_r <= DIV_STEPS;
    end else if (divCnt_r != '0) begin
      divNum_r <= {divNum_r[38:0], remGe};
      divRem_r <= remGe ? remSh - {1'b0, divDen_r} : remSh;
      divCnt_r <= divCnt_r - 6'h01;
    end
  end

  // speed in milli-rev/s and milli-rpm
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      speedRps_r <= '0;
      speedRpm_r <= '0;
    end else if (divCnt_r == 6'h01 && !gateEnd) begin
      speedRps_r <= speedNeg_r ? 32'(-quotNow) : quotNow;
      speedRpm_r <= speedNeg_r ? 32'(-(quotNow * SEC_PER_MIN))
                               : 32'(quotNow * SEC_PER_MIN);
    end
  end

  // shown angle, zero moved by the offset
  always_comb begin
    angleShown = posInRev_r - zoff_r;
    if (posInRev_r < zoff_r)
      angleShown = posInRev_r + edgesPerRev - zoff_r;
  end

  // read port, answer in the following cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (busIn.rd) begin
      unique case (busIn.addr)
        ADDR_CTRL:  rdata <= 32'({multi_r, absEn_r, retry_r,
                                  clear_r, invert_r});
        ADDR_LINES: rdata <= 32'(lines_r);
        ADDR_GMOT:  rdata <= gMot_r;
        ADDR_GLOAD: rdata <= gLoad_r;
        ADDR_ZOFF:  rdata <= 32'(zoff_r);
        ADDR_EDGES: rdata <= edgeCount_r;
        ADDR_RPS:   rdata <= speedRps_r;
        ADDR_RPM:   rdata <= speedRpm_r;
        ADDR_ANGLE: rdata <= 32'(angleShown);
        ADDR_REVS:  rdata <= revCount_r;
        ADDR_LOAD:  rdata <= 32'(loadAngle_r);
        ADDR_CAL:   rdata <= 32'(calState);
        default:    rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_cal_pass;
    state_r == C_MATCH && absIn.valid && !absIn.fault
      && mismatch <= MATCH_TOL && !calStart;
  endsequence

  sequence s_last_try;
    failAttempt && tries_r == CAL_TRIES - 3'h1 && !calStart;
  endsequence

  a_edge_clear:
    assert property (clear_r |=> edgeCount_r == '0)
    else $error("edge counter not held at zero");
  a_edge_step:
    assert property (!clear_r && quad.step && quad.up
      |=> edgeCount_r == $past(edgeCount_r) + 32'sh00000001)
    else $error("up edge not counted");
  a_rev_carry:
    assert property (quad.step && quad.up && !calLoad
      && posInRev_r >= revTop
      |=> revCount_r == $past(revCount_r) + 32'h00000001 ##0
          posInRev_r == '0)
    else $error("turn carry wrong");
  a_rev_loaded:
    assert property (calLoad && multi_r
      |=> revCount_r[11:0] == $past(absIn.revs) && revCount_r[31:12] == '0)
    else $error("turn counter not loaded");
  a_cal_pass:
    assert property (s_cal_pass |=> calState == CAL_DONE ##1 !retry_r
      || $past(setRetry))
    else $error("calibration pass not reported");
  a_cal_failed:
    assert property (s_last_try |=> calState == CAL_FAILED
      && state_r == C_END)
    else $error("failed state not entered");
  a_retry_clear:
    assert property (state_r == C_END && !setRetry |=> !retry_r)
    else $error("retry request not cleared");
  a_not_abs:
    assert property (state_r == C_CHECK && !absEn_r && !calStart
      |=> calState == CAL_NOT_REQ)
    else $error("non-absolute code wrong");
  a_lines_range:
    assert property (lines_r >= LINES_MIN && gMot_r >= GMOT_MIN)
    else $error("setting out of range");
  a_rpm_scale:
    assert property ($changed(speedRps_r)
      |-> speedRpm_r == 32'(speedRps_r * SEC_PER_MIN))
    else $error("rpm not sixty times rps");

endmodule // encoder_position_tracker

// [core/quad_decoder.sv]
`timescale 1ns/10ps
module quad_decoder
  import enc_pkg::*;
(
  // clock and reset
  input  wire logic   mclk,
  input  wire logic   nrst,
  // encoder phases and direction setting
  input  wire phase_s phaseIn,
  input  wire logic   invert,
  // decoded edge event
  output quad_s       quadOut
);

  phase_s     sync1_r;
  phase_s     sync2_r;
  phase_s     prev_r;
  logic [2:0] prime_r;
  quad_s      quad_r;
  logic       chgA;
  logic       chgB;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
      prime_r <= '0;
    end else begin
      sync1_r <= phaseIn;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  // no event until the pipe holds real samples
  assign chgA = (sync2_r.a ^ prev_r.a) & prime_r[2];
  assign chgB = (sync2_r.b ^ prev_r.b) & prime_r[2];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      quad_r <= '0;
    end else begin
      quad_r.step <= chgA ^ chgB;
      quad_r.up   <= ~(prev_r.a ^ sync2_r.b) ^ invert;
      quad_r.bad  <= chgA & chgB;
    end
  end

  assign quadOut = quad_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_double_flip;
    chgA && chgB;
  endsequence

  a_double_ignored:
    assert property (s_double_flip |=> !quadOut.step && quadOut.bad)
    else $error("double phase change counted");
  a_single_counted:
    assert property ((chgA ^ chgB) |=> quadOut.step)
    else $error("single phase edge missed");
  a_sync_depth:
    assert property (quadOut.step |-> $past(phaseIn, 3) != $past(phaseIn, 4))
    else $error("edge seen without two sync stages");

endmodule // quad_decoder
